// File: include/cs_pkg.sv
// cs_pkg: register map, field layout, reset values and states of the
// chopper settings and coil current scaling block.
// assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
// Notes on behaviour
// (R1) With chopper mode 1 the fast decay time sets each fast decay; 0 means slow decay only.
// (R2) With chopper mode 1 the offset code is a signed sine offset, code 3 being zero.
// (R3) With comparator ending enabled, fast decay stops once the negative current passes the positive.
// (R4) The comparator disable bit picks the ending: 0 lets the comparator end it, 1 is time only.
// (R5) While moving, sine values are scaled by (run scale + 1) / 32.
// (R6) The run scale caps what load-adaptive current reduction may ask for.
// (R7) At standstill, sine values are scaled by the hold scale, coded like the run scale.
// (R8) Software should keep the run scale within 16 to 31 for fine microsteps.
// (R9) Software may set hold scales below 16 freely.
// (R10) Power down from run to hold starts only after the standstill wait delay.
// (R11) A power down step delay of 0 jumps straight to the hold scale.
// (R12) Otherwise the scale drops one step per delay times 2^18 clocks until hold is reached.
// (R13) At motion start the scale climbs one step per delay times 512 clocks; 0 is instant.
// (R14) Down steps equal run minus hold; motion during power down turns into power up.
package cs_pkg;
  // bus shape
  localparam int AW   = 4;
  localparam int DW   = 32;
  localparam int SW   = 4;
  localparam int BW   = 8;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // register byte addresses
  localparam logic [AW-1:0] A_CHOP = 4'h0;
  localparam logic [AW-1:0] A_CUR  = 4'h4;
  localparam logic [AW-1:0] A_WAIT = 4'h8;
  localparam logic [AW-1:0] A_STAT = 4'hC;
  // field widths
  localparam int FDW  = 4;
  localparam int OFSW = 4;
  localparam int SCW  = 5;
  localparam int DLYW = 4;
  localparam int WTW  = 16;
  localparam int SINW = 9;
  // field positions
  localparam int CH_FD_LSB    = 0;
  localparam int CH_OFS_LSB   = 4;
  localparam int CH_DIS_BIT   = 8;
  localparam int CH_CHM_BIT   = 9;
  localparam int CU_HOLD_LSB  = 0;
  localparam int CU_RUN_LSB   = 8;
  localparam int CU_PDD_LSB   = 16;
  localparam int CU_PUD_LSB   = 24;
  localparam int WT_LSB       = 0;
  localparam int ST_SCL_LSB   = 0;
  localparam int ST_HOLD_BIT  = 8;
  localparam int ST_BUSY_BIT  = 9;
  localparam int ST_FD_BIT    = 10;
  // reset values
  localparam logic [FDW-1:0]  RST_FD   = 4'h5;
  localparam logic [OFSW-1:0] RST_OFS  = 4'h2;
  localparam logic            RST_DIS  = 1'h0;
  localparam logic            RST_CHM  = 1'h0;
  localparam logic [SCW-1:0]  RST_RUN  = 5'h1F;
  localparam logic [SCW-1:0]  RST_HOLD = 5'h08;
  localparam logic [DLYW-1:0] RST_PDD  = 4'h1;
  localparam logic [DLYW-1:0] RST_PUD  = 4'h4;
  localparam logic [WTW-1:0]  RST_WAIT = 16'h0200;
  // offset code that means zero offset
  localparam logic signed [OFSW:0] OFS_ZERO = 5'sh03;
  // clocks per delay unit
  localparam int HOLD_UNIT_DEF = 262144;
  localparam int RUN_UNIT_DEF  = 512;
  localparam int FD_UNIT_DEF   = 32;
  typedef enum logic [2:0] {SC_RUN, SC_WAIT, SC_DOWN, SC_HOLD, SC_UP} cs_scl_t;
endpackage

// File: src/cs_tmr.sv
// cs_tmr: reloadable down counter that flags the last cycle of an interval.
// assumes start is a one-cycle request from logic on aclk.
`timescale 1ns/1ns
module cs_tmr #(
  parameter int TW = 24
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // control
  input  wire logic          start,
  input  wire logic [TW-1:0] period,
  // status
  output logic               done
);
  logic [TW-1:0] cnt_q;

  // a zero period never flags; callers keep zero delays out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= period;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - TW'(1);
    end
  end

  assign done = (cnt_q == TW'(1));
endmodule

// File: src/cs_chopper_scaling.sv
// cs_chopper_scaling: constant off-time chopper settings and coil current
// scaling with standstill power down and motion power up.
// assumes an AXI4-Lite master on aclk, motion flag, chopper start and
// sine values from logic on aclk, and an asynchronous current comparator.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module cs_chopper_scaling #(
  parameter int TW        = 24,
  parameter int HOLD_UNIT = cs_pkg::HOLD_UNIT_DEF,
  parameter int RUN_UNIT  = cs_pkg::RUN_UNIT_DEF,
  parameter int FD_UNIT   = cs_pkg::FD_UNIT_DEF
) (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // write address
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [cs_pkg::AW-1:0]          awaddr,
  // write data
  input  wire logic                           wvalid,
  output logic                                wready,
  input  wire logic [cs_pkg::DW-1:0]          wdata,
  input  wire logic [cs_pkg::SW-1:0]          wstrb,
  // write response
  output logic                                bvalid,
  input  wire logic                           bready,
  output logic [1:0]                          bresp,
  // read
  input  wire logic                           arvalid,
  output logic                                arready,
  input  wire logic [cs_pkg::AW-1:0]          araddr,
  output logic                                rvalid,
  input  wire logic                           rready,
  output logic [cs_pkg::DW-1:0]               rdata,
  output logic [1:0]                          rresp,
  // motion and chopper events
  input  wire logic                           motion_active,
  input  wire logic                           fd_start,
  input  wire logic                           cmp_neg_over,
  // current values in
  input  wire logic signed [cs_pkg::SINW-1:0] sine_in,
  input  wire logic [cs_pkg::SCW-1:0]         load_adapt_req,
  // chopper outputs
  output logic                                fast_decay_on,
  output logic signed [cs_pkg::OFSW:0]        sine_offset,
  // current outputs
  output logic [cs_pkg::SCW-1:0]              scale_out,
  output logic signed [cs_pkg::SINW-1:0]      coil_cur,
  output logic [cs_pkg::SCW-1:0]              load_adapt_lim
);
  import cs_pkg::*;

  // configuration
  logic [FDW-1:0]         fd_q;
  logic [OFSW-1:0]        ofs_q;
  logic                   dis_q;
  logic                   chm_q;
  logic [SCW-1:0]         run_q;
  logic [SCW-1:0]         hold_q;
  logic [DLYW-1:0]        pdd_q;
  logic [DLYW-1:0]        pud_q;
  logic [WTW-1:0]         wait_q;
  // bus
  logic                   aw_full_q;
  logic                   w_full_q;
  logic [AW-1:0]          aw_addr_q;
  logic [DW-1:0]          w_data_q;
  logic [SW-1:0]          w_strb_q;
  logic                   wr_do;
  logic [DW-1:0]          wr_word;
  // chopper
  logic                   cmp_s1_q;
  logic                   cmp_s2_q;
  logic                   fd_go;
  logic                   fd_done;
  logic [TW-1:0]          fd_per;
  logic [TW-1:0]          fd_len_q;
  // scaling
  cs_scl_t                st_q;
  cs_scl_t                st_d;
  logic [SCW-1:0]         scale_q;
  logic [SCW-1:0]         scale_d;
  logic                   up_req;
  logic                   step_go;
  logic                   step_done;
  logic [TW-1:0]          step_per;
  logic [WTW-1:0]         wt_cnt_q;
  logic                   wait_hit;
  logic signed [SCW+1:0]  scl_p1;
  logic signed [SINW+SCW+1:0] prod;

  function automatic logic hit(input logic [AW-1:0] a);
    return a == A_CHOP || a == A_CUR || a == A_WAIT || a == A_STAT;
  endfunction

  function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o,
                                        input logic [DW-1:0] n,
                                        input logic [SW-1:0] s);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < SW; i++) begin
      if (s[i]) r[i*BW +: BW] = n[i*BW +: BW];
    end
    return r;
  endfunction

  // unmapped addresses read as zero; reserved bits read as zero
  function automatic logic [DW-1:0] reg_word(input logic [AW-1:0] a);
    logic [DW-1:0] r;
    r = '0;
    case (a)
      A_CHOP: begin
        r[CH_FD_LSB +: FDW]   = fd_q;
        r[CH_OFS_LSB +: OFSW] = ofs_q;
        r[CH_DIS_BIT]         = dis_q;
        r[CH_CHM_BIT]         = chm_q;
      end
      A_CUR: begin
        r[CU_HOLD_LSB +: SCW] = hold_q;
        r[CU_RUN_LSB +: SCW]  = run_q;
        r[CU_PDD_LSB +: DLYW] = pdd_q;
        r[CU_PUD_LSB +: DLYW] = pud_q;
      end
      A_WAIT: r[WT_LSB +: WTW] = wait_q;
      A_STAT: begin
        r[ST_SCL_LSB +: SCW] = scale_q;
        r[ST_HOLD_BIT]       = (st_q == SC_HOLD);
        r[ST_BUSY_BIT]       = (st_q == SC_DOWN) || (st_q == SC_UP);
        r[ST_FD_BIT]         = fast_decay_on;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // write channel: address and data taken in either order
  assign awready = !aw_full_q;
  assign wready  = !w_full_q;
  assign wr_do   = aw_full_q && w_full_q && !bvalid;
  assign wr_word = mrg(reg_word(aw_addr_q), w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
    end else if (wr_do) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
    end else if (wr_do) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (awvalid && awready) aw_addr_q <= awaddr;
    if (wvalid && wready) begin
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OK;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp  <= hit(aw_addr_q) ? RESP_OK : RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel: one read in flight, data from a register
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= reg_word(araddr);
      rresp  <= hit(araddr) ? RESP_OK : RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // configuration registers; the status word ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fd_q   <= RST_FD;
      ofs_q  <= RST_OFS;
      dis_q  <= RST_DIS;
      chm_q  <= RST_CHM;
      run_q  <= RST_RUN;
      hold_q <= RST_HOLD;
      pdd_q  <= RST_PDD;
      pud_q  <= RST_PUD;
      wait_q <= RST_WAIT;
    end else if (wr_do && aw_addr_q == A_CHOP) begin
      fd_q  <= wr_word[CH_FD_LSB +: FDW];
      ofs_q <= wr_word[CH_OFS_LSB +: OFSW];
      dis_q <= wr_word[CH_DIS_BIT];
      chm_q <= wr_word[CH_CHM_BIT];
    end else if (wr_do && aw_addr_q == A_CUR) begin
      hold_q <= wr_word[CU_HOLD_LSB +: SCW];
      run_q  <= wr_word[CU_RUN_LSB +: SCW];
      pdd_q  <= wr_word[CU_PDD_LSB +: DLYW];
      pud_q  <= wr_word[CU_PUD_LSB +: DLYW];
    end else if (wr_do && aw_addr_q == A_WAIT) begin
      wait_q <= wr_word[WT_LSB +: WTW];
    end
  end

  // comparator is analog and asynchronous to aclk
  always_ff @(posedge aclk) begin
    cmp_s1_q <= cmp_neg_over;
    cmp_s2_q <= cmp_s1_q;
  end

  // fast decay phase; a zero setting never starts one
  assign fd_per = TW'(fd_q) * TW'(FD_UNIT);
  assign fd_go  = fd_start && chm_q && fd_q != '0 && !fast_decay_on; // R1

  cs_tmr #(.TW(TW)) u_fd_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (fd_go),
    .period  (fd_per),
    .done    (fd_done)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !chm_q) begin
      fast_decay_on <= 1'b0;
    end else if (fd_go) begin
      fast_decay_on <= 1'b1;
    end else if (fd_done || (cmp_s2_q && !dis_q)) begin
      fast_decay_on <= 1'b0; // R3 R4
    end
  end

  // offset code minus three, zero outside chopper mode 1
  always_ff @(posedge aclk) begin
    if (!aresetn || !chm_q) begin
      sine_offset <= '0;
    end else begin
      sine_offset <= $signed({1'b0, ofs_q}) - OFS_ZERO; // R2
    end
  end

  // standstill wait counter, restarted on every entry to the wait state
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q != SC_WAIT) begin
      wt_cnt_q <= '0;
    end else if (!wait_hit) begin
      wt_cnt_q <= wt_cnt_q + WTW'(1);
    end
  end

  assign wait_hit = wt_cnt_q >= wait_q; // R10

  // one step timer serves both directions; motion picks the step length
  assign step_per = motion_active ? TW'(pud_q) * TW'(RUN_UNIT)
                                  : TW'(pdd_q) * TW'(HOLD_UNIT); // R12 R13

  cs_tmr #(.TW(TW)) u_step_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (step_go),
    .period  (step_per),
    .done    (step_done)
  );

  always_comb begin
    st_d    = st_q;
    scale_d = scale_q;
    step_go = 1'b0;
    up_req  = 1'b0;
    unique case (st_q)
      SC_RUN: begin
        scale_d = run_q; // R5
        if (!motion_active) st_d = SC_WAIT;
      end
      SC_WAIT: begin
        if (motion_active) begin
          up_req = 1'b1;
        end else if (wait_hit && pdd_q == '0) begin
          st_d    = SC_HOLD; // R11
          scale_d = hold_q;
        end else if (wait_hit) begin
          st_d    = SC_DOWN; // R10
          step_go = 1'b1;
        end
      end
      SC_DOWN: begin
        if (motion_active) begin
          up_req = 1'b1; // R14
        end else if (scale_q <= hold_q) begin
          st_d    = SC_HOLD;
          scale_d = hold_q;
        end else if (step_done) begin
          scale_d = scale_q - SCW'(1); // R12 R14
          if (scale_d <= hold_q) st_d = SC_HOLD;
          else step_go = 1'b1;
        end
      end
      SC_HOLD: begin
        scale_d = hold_q; // R7
        if (motion_active) up_req = 1'b1;
      end
      SC_UP: begin
        if (!motion_active) begin
          st_d = SC_WAIT;
        end else if (scale_q >= run_q) begin
          st_d    = SC_RUN;
          scale_d = run_q;
        end else if (step_done) begin
          scale_d = scale_q + SCW'(1); // R13
          if (scale_d >= run_q) st_d = SC_RUN;
          else step_go = 1'b1;
        end
      end
    endcase
    if (up_req) begin
      if (pud_q == '0 || scale_q >= run_q) begin
        st_d    = SC_RUN; // R13
        scale_d = run_q;
      end else begin
        st_d    = SC_UP;
        step_go = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= SC_HOLD;
      scale_q <= RST_HOLD;
    end else begin
      st_q    <= st_d;
      scale_q <= scale_d;
    end
  end

  // sine value times (scale + 1) / 32
  assign scl_p1    = $signed({2'b00, scale_q}) + 7'sh01;
  assign prod      = sine_in * scl_p1;
  assign scale_out = scale_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_cur       <= '0;
      load_adapt_lim <= '0;
    end else begin
      coil_cur       <= prod[SCW +: SINW]; // R5 R7
      load_adapt_lim <= (load_adapt_req > run_q) ? run_q : load_adapt_req; // R6
    end
  end

  // checks
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) begin
    if (!aresetn || !fast_decay_on) fd_len_q <= '0;
    else fd_len_q <= fd_len_q + TW'(1);
  end

  sequence s_still_done;
    st_q == SC_WAIT && wait_hit && !motion_active;
  endsequence

  sequence s_fd_timed;
    dis_q && chm_q && fast_decay_on && !fd_done ##1 chm_q;
  endsequence

  fd_zero_a: assert property (fd_start && chm_q && fd_q == '0 |=> !fast_decay_on) // R1
    else $error("fast decay started with zero length");
  fd_len_a: assert property (fast_decay_on |-> fd_len_q < fd_per) // R1
    else $error("fast decay ran past its length");
  ofs_sign_a: assert property (chm_q ##1 chm_q |-> (sine_offset > 0) == ($past(ofs_q) > 4'h3)) // R2
    else $error("sine offset sign wrong");
  cmp_end_a: assert property (fast_decay_on && cmp_s2_q && !dis_q |=> !fast_decay_on) // R3
    else $error("comparator did not end fast decay");
  time_only_a: assert property (s_fd_timed |-> fast_decay_on) // R4
    else $error("fast decay ended early in time only mode");
  run_track_a: assert property (st_q == SC_RUN && $past(st_q) == SC_RUN |-> scale_out == $past(run_q)) // R5
    else $error("run scale not applied");
  lim_cap_a: assert property (motion_active |=> load_adapt_lim <= $past(run_q)) // R6
    else $error("load adaptive current above run scale");
  hold_track_a: assert property (st_q == SC_HOLD && $past(st_q) == SC_HOLD |-> scale_out == $past(hold_q)) // R7
    else $error("hold scale not applied");
  wait_keep_a: assert property (st_q == SC_WAIT && !wait_hit && !motion_active |=> scale_q == $past(scale_q)) // R10
    else $error("current changed before standstill wait");
  hold_jump_a: assert property (s_still_done ##0 pdd_q == '0 |=> st_q == SC_HOLD && scale_q == $past(hold_q)) // R11
    else $error("zero delay did not jump to hold");
  dn_step_a: assert property (st_q == SC_DOWN && !motion_active && scale_q > hold_q |=> scale_q == $past(scale_q) - SCW'($past(step_done))) // R12
    else $error("power down step wrong");
  up_step_a: assert property (st_q == SC_UP && motion_active && scale_q < run_q |=> scale_q == $past(scale_q) + SCW'($past(step_done))) // R13
    else $error("power up step wrong");
  abort_up_a: assert property (st_q == SC_DOWN && motion_active |=> st_q inside {SC_UP, SC_RUN}) // R14
    else $error("motion did not abort power down");
endmodule

// File: verif/cs_reg_model.sv
// cs_reg_model: stand-in for the phase current regulator that starts fast
// decays and trips the current comparator; assumes fast_decay_on from the block.
`timescale 1ns/1ns
module cs_reg_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench control
  input  wire logic       go,
  input  wire logic [7:0] trip_after,
  // block side
  input  wire logic       fast_decay_on,
  output logic            fd_start,
  output logic            cmp_neg_over
);
  logic [7:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fd_start <= 1'b0;
    end else begin
      fd_start <= go;
    end
  end

  // trips in time-only mode too, so a block that wrongly listens is caught
  always_ff @(posedge aclk) begin
    if (!aresetn || !fast_decay_on) begin
      cnt_q        <= 8'h00;
      cmp_neg_over <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      if (trip_after != 8'h00 && cnt_q + 8'h01 >= trip_after) begin
        cmp_neg_over <= 1'b1;
      end
    end
  end
endmodule

// File: verif/tb_chopper_current_scaling.sv
// tb_chopper_current_scaling: self-checking bench for chopper settings and
// current scaling; assumes delay units shortened through parameters.
`timescale 1ns/1ns
module tb_chopper_current_scaling;
  import cs_pkg::*;
  localparam int FU = 2;
  typedef struct {logic [31:0] chop; logic signed [8:0] sin; logic signed [4:0] ofs;} cs_row_t;
  cs_row_t rows [6] = '{'{32'h205, 9'sd100, -5'sd3}, '{32'h235, -9'sd100, 5'sd0},
    '{32'h275, 9'sd255, 5'sd4}, '{32'h2F5, -9'sd256, 5'sd12},
    '{32'h075, 9'sd0, 5'sd0}, '{32'h325, 9'sd50, -5'sd1}};
  logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid, go;
  logic [AW-1:0]          awaddr, araddr;
  logic [DW-1:0]          wdata, rdata;
  logic [SW-1:0]          wstrb;
  logic [1:0]             bresp, rresp;
  logic                   motion_active, fd_start, cmp_neg_over, fast_decay_on;
  logic [7:0]             trip_after;
  logic signed [SINW-1:0] sine_in, coil_cur;
  logic [SCW-1:0]         load_adapt_req, scale_out, load_adapt_lim;
  logic signed [OFSW:0]   sine_offset;
  int                     errors, n_compared, nchg, t_first, gmin, gmax, nbad, len;

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  cs_chopper_scaling #(.TW(24), .HOLD_UNIT(16), .RUN_UNIT(8), .FD_UNIT(FU)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .motion_active(motion_active), .fd_start(fd_start), .cmp_neg_over(cmp_neg_over),
    .sine_in(sine_in), .load_adapt_req(load_adapt_req), .fast_decay_on(fast_decay_on),
    .sine_offset(sine_offset), .scale_out(scale_out), .coil_cur(coil_cur),
    .load_adapt_lim(load_adapt_lim));

  cs_reg_model u_reg (.aclk(aclk), .aresetn(aresetn), .go(go), .trip_after(trip_after),
    .fast_decay_on(fast_decay_on), .fd_start(fd_start), .cmp_neg_over(cmp_neg_over));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // bready stays up between writes; each call drives it high again before the wait
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rdk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask

  task automatic fd_len(input logic [7:0] trip);
    trip_after <= trip;
    go         <= 1'b1;
    @(posedge aclk);
    go  <= 1'b0;
    len = 0;
    repeat (70) begin
      @(posedge aclk);
      if (fast_decay_on === 1'b1) len++;
    end
  endtask

  // records count, timing and size of scale changes over n cycles
  task automatic watch(input int n);
    logic [4:0] prev;
    int last;
    prev = scale_out;
    last = 0;
    nchg = 0;
    nbad = 0;
    gmin = 999;
    gmax = 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge aclk);
      if (scale_out !== prev) begin
        if (nchg > 0 && i - last < gmin) gmin = i - last;
        if (nchg > 0 && i - last > gmax) gmax = i - last;
        if (nchg == 0) t_first = i;
        if (scale_out != prev + 5'h01 && scale_out != prev - 5'h01) nbad++;
        nchg++;
        last = i;
        prev = scale_out;
      end
    end
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // about ten times the expected run length
  initial begin
    #(100 * 8000);
    errors++;
    give_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, motion_active} = 8'h00;
    {awaddr, araddr, wdata, wstrb, trip_after} = '0;
    sine_in = '0;
    load_adapt_req = '0;
    errors = 0;
    n_compared = 0;
    do_reset();
    for (int i = 0; i < 6; i++) begin
      wr(A_CHOP, rows[i].chop, RESP_OK);
      sine_in <= rows[i].sin;
      repeat (3) @(posedge aclk);
      chk(32'(sine_offset), 32'(rows[i].ofs));
      chk(32'(coil_cur), (int'(rows[i].sin) * 9) >>> 5);
      rdk(A_CHOP, rows[i].chop, RESP_OK);
    end
    $display("test offsets done");
    wr(A_CHOP, 32'h303, RESP_OK);
    fd_len(8'h02);
    chk(len, 3 * FU);
    wr(A_CHOP, 32'h20F, RESP_OK);
    fd_len(8'h04);
    chk(32'(len > 4 && len < 12), 32'h1);
    wr(A_CHOP, 32'h200, RESP_OK);
    fd_len(8'h00);
    chk(len, 0);
    wr(A_CHOP, 32'h005, RESP_OK);
    fd_len(8'h00);
    chk(len, 0);
    $display("test fast decay done");
    sine_in <= 9'sd100;
    wr(A_WAIT, 32'h4, RESP_OK);
    wr(A_CUR, 32'h0001_100A, RESP_OK);
    motion_active <= 1'b1;
    watch(5);
    chk(32'(scale_out), 32'd16);
    load_adapt_req <= 5'd25;
    repeat (3) @(posedge aclk);
    chk(32'(coil_cur), 32'd53);
    chk(32'(load_adapt_lim), 32'd16);
    load_adapt_req <= 5'd7;
    repeat (3) @(posedge aclk);
    chk(32'(load_adapt_lim), 32'd7);
    motion_active <= 1'b0;
    watch(140);
    chk(32'(t_first >= 18 && t_first <= 26), 32'h1);
    chk(32'(gmin >= 16 && gmax <= 17), 32'h1);
    chk(nchg, 6);
    chk(nbad, 0);
    chk(32'(scale_out), 32'd10);
    chk(32'(coil_cur), 32'd34);
    wr(A_CUR, 32'h0000_100A, RESP_OK);
    motion_active <= 1'b1;
    watch(5);
    motion_active <= 1'b0;
    watch(30);
    chk(nchg, 1);
    chk(32'(t_first >= 5 && t_first <= 8), 32'h1);
    chk(32'(scale_out), 32'd10);
    wr(A_CUR, 32'h0102_100A, RESP_OK);
    motion_active <= 1'b1;
    watch(60);
    chk(nchg, 6);
    chk(32'(gmin >= 8 && gmax <= 9), 32'h1);
    chk(32'(scale_out), 32'd16);
    motion_active <= 1'b0;
    watch(80);
    chk(nchg, 2);
    motion_active <= 1'b1;
    watch(30);
    chk(32'(t_first <= 10 && nchg == 2 && nbad == 0), 32'h1);
    chk(32'(scale_out), 32'd16);
    $display("test scaling done");
    // standstill across reset, else the hold state at once starts a power up
    motion_active <= 1'b0;
    do_reset();
    chk(32'(scale_out), 32'd8);
    rdk(A_CHOP, 32'h25, RESP_OK);
    rdk(A_CUR, 32'h0401_1F08, RESP_OK);
    rdk(A_WAIT, 32'h200, RESP_OK);
    wr(A_STAT, 32'hFFFF_FFFF, RESP_OK);
    rdk(A_STAT, 32'h108, RESP_OK);
    wr(4'h2, 32'hFFFF_FFFF, RESP_ERR);
    rdk(4'h2, 32'h0, RESP_ERR);
    $display("test reset and map done");
    give_verdict();
  end
endmodule
